// ### core/asp_pkg.sv
// asp_pkg: constants shared by the serial port core and its baud generator
// assumes a 40 MHz system clock and an APB register bus
package asp_pkg;
    // ****************************************************************
    // register map (word indices; byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] ASP_CTRL_OFFSET     = 8'h98;
    localparam logic [7:0] ASP_DATA_OFFSET     = 8'h99;
    localparam logic [7:0] ASP_TIMER_OFFSET    = 8'hA0;
    localparam logic [7:0] ASP_CTRL_RESET      = 8'h00;
    localparam logic [7:0] ASP_DATA_RESET      = 8'h00;
    localparam logic [7:0] ASP_TIMER_RESET     = 8'h00;
    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int         ASP_MODE_BIT        = 7;
    localparam int         ASP_UNUSED_BIT      = 6;
    localparam int         ASP_MCE_BIT         = 5;
    localparam int         ASP_REN_BIT         = 4;
    localparam int         ASP_TB8_BIT         = 3;
    localparam int         ASP_RB8_BIT         = 2;
    localparam int         ASP_TI_BIT          = 1;
    localparam int         ASP_RI_BIT          = 0;
    // ****************************************************************
    // timer control register fields (own register)
    // ****************************************************************
    localparam int         ASP_TRUN_BIT        = 0;
    localparam int         ASP_TSEL_LSB        = 1;
    localparam int         ASP_RELOAD_LSB      = 8;
    // ****************************************************************
    // baud timer clock sources and prescale figures
    // ****************************************************************
    typedef enum logic [2:0]
    {
        ASP_SRC_SYS     = 3'h0,
        ASP_SRC_DIV4    = 3'h1,
        ASP_SRC_DIV12   = 3'h2,
        ASP_SRC_DIV48   = 3'h3,
        ASP_SRC_EXT8    = 3'h4
    } asp_src_type;
    localparam int         ASP_DIV4            = 4;
    localparam int         ASP_DIV12           = 12;
    localparam int         ASP_DIV48           = 48;
    localparam int         ASP_EXT_DIV         = 8;
    localparam int         ASP_TIMER_SPAN      = 256;
    localparam int         ASP_OVF_PER_BIT     = 2;
    localparam int         ASP_BITS_8          = 10;
    localparam int         ASP_BITS_9          = 11;
endpackage

// ### core/asp_tick_if.sv
// asp_tick_if: enables passed from the baud generator to the serial core, and the rx restart passed back
// assumes one clock domain; all signals are one-cycle pulses or levels
`timescale 1ns/1ps
interface asp_tick_if;
    logic       tx_tick;    // transmit bit-time pulse
    logic       rx_tick;    // receive bit-time pulse
    logic       rx_mid;     // receive mid-bit sample pulse
    logic       rx_restart; // force reload of receive timer
    modport gen (output tx_tick, output rx_tick, output rx_mid, input rx_restart);
    modport core (input tx_tick, input rx_tick, input rx_mid, output rx_restart);
endinterface

// ### core/asp_baud_gen.sv
// asp_baud_gen: prescaler, 8-bit auto-reload transmit timer and hidden rx copy
// assumes ext_clk_i is a level synchronous to mclk_i
`timescale 1ns/1ps
module asp_baud_gen
(
    input  wire logic                 mclk_i,    // system clock
    input  wire logic                 rst_n_i,   // sync reset, active low
    input  wire logic                 run_i,     // timer enable
    input  wire asp_pkg::asp_src_type src_i,     // timer clock source
    input  wire logic [7:0]           reload_i,  // reload byte
    input  wire logic                 ext_clk_i, // external oscillator level
    asp_tick_if.gen                   tk         // bit-time enables
);
    import asp_pkg::*;

    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    logic       ext_q;
    logic [7:0] tx_low;
    logic [7:0] rx_low;
    logic       tx_half;
    logic       rx_half;

    wire ext_rise  = ext_clk_i & ~ext_q;
    wire p4        = (pre_cnt % 6'(ASP_DIV4)) == 6'h0;
    wire p12       = (pre_cnt % 6'(ASP_DIV12)) == 6'h0;
    wire p48       = pre_cnt == 6'h0;
    wire src_ext   = (src_i == ASP_SRC_EXT8);
    // every eighth oscillator rise
    wire ext_edge8 = ext_rise && ext_cnt == 3'(ASP_EXT_DIV - 1) && src_ext;
    wire tclk_en   = run_i && ((src_i == ASP_SRC_SYS)   ? 1'b1 :
                               (src_i == ASP_SRC_DIV4)  ? p4   :
                               (src_i == ASP_SRC_DIV12) ? p12  :
                               (src_i == ASP_SRC_DIV48) ? p48  : ext_edge8);
    wire tx_ovf    = tclk_en && tx_low == 8'hFF;
    wire rx_ovf    = tclk_en && rx_low == 8'hFF && !tk.rx_restart;

    // ****************************************************************
    // baud rate = timer clock / (256 - reload) / 2
    // ****************************************************************
    // halved overflow streams
    assign tk.tx_tick = tx_ovf && tx_half;
    assign tk.rx_tick = rx_ovf && rx_half;
    assign tk.rx_mid  = rx_ovf && !rx_half;

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            pre_cnt <= 6'h0;
            ext_cnt <= 3'h0;
            ext_q   <= 1'b0;
            tx_low  <= 8'h00;
            rx_low  <= 8'h00;
            tx_half <= 1'b0;
            rx_half <= 1'b0;
        end
        else
        begin
            ext_q <= ext_clk_i;
            pre_cnt <= (pre_cnt == 6'(ASP_DIV48 - 1)) ? 6'h0 : pre_cnt + 6'h1;
            if (ext_rise)
                ext_cnt <= ext_cnt + 3'h1;
            if (tclk_en)
                tx_low <= (tx_low == 8'hFF) ? reload_i : tx_low + 8'h1;
            if (tx_ovf)
                tx_half <= ~tx_half;
            if (tk.rx_restart)
            begin
                rx_low  <= reload_i;
                rx_half <= 1'b0;
            end
            else if (tclk_en)
            begin
                rx_low <= (rx_low == 8'hFF) ? reload_i : rx_low + 8'h1;
                if (rx_ovf)
                    rx_half <= ~rx_half;
            end
        end
    end
endmodule

// ### core/asp_uart.sv
// asp_uart: 8/9-bit asynchronous serial port with APB register access
// assumes rx_i is synchronous to mclk_i; interrupt controller lies outside
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module asp_uart
(
    input  wire logic        mclk_i,    // 40 MHz system clock
    input  wire logic        rst_n_i,   // sync reset, active low
    input  wire logic        psel_i,    // apb select
    input  wire logic        penable_i, // apb enable
    input  wire logic        pwrite_i,  // apb write
    input  wire logic [9:0]  paddr_i,   // apb byte address
    input  wire logic [31:0] pwdata_i,  // apb write data
    output logic      [31:0] prdata_o,  // apb read data
    output logic             pready_o,  // apb ready
    output logic             pslverr_o, // apb error, unmapped address
    input  wire logic        rx_i,      // serial receive pin
    input  wire logic        ext_clk_i, // external oscillator level
    output logic             tx_o,      // serial transmit pin
    output logic             irq_o      // done-flag request
);
    import asp_pkg::*;

    typedef enum logic [1:0]
    {
        ASP_RX_IDLE  = 2'b00,
        ASP_RX_START = 2'b01,
        ASP_RX_DATA  = 2'b10,
        ASP_RX_STOP  = 2'b11
    } asp_rx_type;

    asp_tick_if tk ();

    // ****************************************************************
    // registers
    // ****************************************************************
    logic       mode9;
    logic       mce;
    logic       ren;
    logic       tb8;
    logic       rb8;
    logic       ti;
    logic       ri;
    logic [7:0] rx_buf;
    logic       t_run;
    logic [2:0] t_src;
    logic [7:0] t_reload;

    // transmitter
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic        tx_busy;
    logic        tx_q;

    // receiver
    asp_rx_type rx_st;
    asp_rx_type next_rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic       rx_q;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // word index sits above the two byte-lane bits
    function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
        reg_hit = addr == {idx, 2'b00};
    endfunction

    wire acc       = psel_i && penable_i;
    wire hit_ctrl  = reg_hit(paddr_i, ASP_CTRL_OFFSET);
    wire hit_data  = reg_hit(paddr_i, ASP_DATA_OFFSET);
    wire hit_timer = reg_hit(paddr_i, ASP_TIMER_OFFSET);
    wire unmapped  = !(hit_ctrl || hit_data || hit_timer);
    wire wr_ctrl   = acc && pwrite_i && hit_ctrl;
    wire wr_data   = acc && pwrite_i && hit_data;
    wire wr_timer  = acc && pwrite_i && hit_timer;

    wire [7:0] ctrl_rd = {mode9, 1'b1, mce, ren, tb8, rb8, ti, ri};
    wire [31:0] timer_rd = {16'h0, t_reload, 4'h0, t_src, t_run};
    wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_rd} :
                         hit_data ? {24'h0, rx_buf} :
                         hit_timer ? timer_rd : 32'h0;

    assign pready_o  = 1'b1;
    assign pslverr_o = acc && unmapped;

    // ****************************************************************
    // receive datapath decode
    // ****************************************************************
    wire rx_fall   = rx_q && !rx_i;
    // index of the last data sample, stop excluded
    wire [3:0] rx_last = mode9 ? 4'(ASP_BITS_9 - 3) : 4'(ASP_BITS_8 - 3);
    wire ninth_in  = mode9 ? rx_sh[8] : rx_i;
    wire accept    = !ri && (!mce || ninth_in);
    wire stop_samp = (rx_st == ASP_RX_STOP) && tk.rx_mid;
    wire rx_set    = stop_samp && accept;

    // reload rx timer on start edge
    assign tk.rx_restart = (rx_st == ASP_RX_IDLE) && rx_fall && ren;

    // ****************************************************************
    // transmit decode
    // ****************************************************************
    wire [3:0] tx_len  = mode9 ? 4'(ASP_BITS_9) : 4'(ASP_BITS_8);
    wire tx_end    = tx_busy && tk.tx_tick && (tx_cnt == tx_len - 4'h1);
    wire tx_fin    = tx_busy && tk.tx_tick && (tx_cnt == tx_len);

    assign irq_o = ti || ri;
    assign tx_o  = tx_q;

    asp_baud_gen u_baud
    (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (t_run),
        .src_i     (asp_src_type'(t_src)),
        .reload_i  (t_reload),
        .ext_clk_i (ext_clk_i),
        .tk        (tk)
    );

    // ****************************************************************
    // receive state machine
    // ****************************************************************
    always_comb
    begin
        next_rx_st = rx_st;
        case (rx_st)
            ASP_RX_IDLE:
                if (tk.rx_restart)
                    next_rx_st = ASP_RX_START;
            ASP_RX_START:
                if (tk.rx_mid)
                    next_rx_st = rx_i ? ASP_RX_IDLE : ASP_RX_DATA;
            ASP_RX_DATA:
                if (tk.rx_mid && rx_cnt == rx_last)
                    next_rx_st = ASP_RX_STOP;
            ASP_RX_STOP:
                if (tk.rx_mid)
                    next_rx_st = ASP_RX_IDLE;
            default:
                next_rx_st = ASP_RX_IDLE;
        endcase
        if (!ren)
            next_rx_st = ASP_RX_IDLE;
    end

    // ****************************************************************
    // clocked state
    // ****************************************************************
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            rx_st  <= ASP_RX_IDLE;
            rx_sh  <= 9'h000;
            rx_cnt <= 4'h0;
            rx_q   <= 1'b1;
        end
        else
        begin
            rx_st <= next_rx_st;
            rx_q  <= rx_i;
            if (rx_st == ASP_RX_START)
                rx_cnt <= 4'h0;
            else if (rx_st == ASP_RX_DATA && tk.rx_mid)
            begin
                rx_sh  <= {rx_i, rx_sh[8:1]};
                rx_cnt <= rx_cnt + 4'h1;
            end
        end
    end

    // ****************************************************************
    // receive buffer
    // ****************************************************************
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            rx_buf <= ASP_DATA_RESET;
            rb8    <= 1'b0;
        end
        else if (rx_set)
        begin
            rx_buf <= mode9 ? rx_sh[7:0] : rx_sh[8:1];
            rb8    <= ninth_in;
        end
        else if (wr_ctrl)
            rb8 <= pwdata_i[ASP_RB8_BIT];
    end

    // ****************************************************************
    // control and timer registers
    // ****************************************************************
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            mode9    <= ASP_CTRL_RESET[ASP_MODE_BIT];
            mce      <= ASP_CTRL_RESET[ASP_MCE_BIT];
            ren      <= ASP_CTRL_RESET[ASP_REN_BIT];
            tb8      <= ASP_CTRL_RESET[ASP_TB8_BIT];
            ti       <= ASP_CTRL_RESET[ASP_TI_BIT];
            ri       <= ASP_CTRL_RESET[ASP_RI_BIT];
            t_run    <= ASP_TIMER_RESET[ASP_TRUN_BIT];
            t_src    <= ASP_TIMER_RESET[ASP_TSEL_LSB +: 3];
            t_reload <= ASP_TIMER_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                mode9 <= pwdata_i[ASP_MODE_BIT];
                mce   <= pwdata_i[ASP_MCE_BIT];
                ren   <= pwdata_i[ASP_REN_BIT];
                tb8   <= pwdata_i[ASP_TB8_BIT];
            end
            ti <= tx_end | (wr_ctrl ? pwdata_i[ASP_TI_BIT] : ti);
            ri <= rx_set | (wr_ctrl ? pwdata_i[ASP_RI_BIT] : ri);
            if (wr_timer)
            begin
                t_run    <= pwdata_i[ASP_TRUN_BIT];
                t_src    <= pwdata_i[ASP_TSEL_LSB +: 3];
                t_reload <= pwdata_i[ASP_RELOAD_LSB +: 8];
            end
        end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            tx_sh   <= 11'h7FF;
            tx_cnt  <= 4'h0;
            tx_busy <= 1'b0;
            tx_q    <= 1'b1;
        end
        else if (wr_data)
        begin
            // start bit waits for the next bit tick so it keeps full length
            tx_sh   <= mode9 ? {1'b1, tb8, pwdata_i[7:0], 1'b0} : {2'b11, pwdata_i[7:0], 1'b0};
            tx_cnt  <= 4'h0;
            tx_busy <= 1'b1;
        end
        else if (tx_busy && tk.tx_tick)
        begin
            tx_q   <= tx_sh[0];
            tx_sh  <= {1'b1, tx_sh[10:1]};
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_fin)
            begin
                tx_busy <= 1'b0;
                tx_q    <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // read data register
    // ****************************************************************
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            prdata_o <= 32'h0;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= rd_mux;
    end
endmodule

// ### verif/asp_uart_chk.sv
// asp_uart_chk: port assertions for the serial port
// assumes binding to asp_uart, one clock domain
`timescale 1ns/1ps
module asp_uart_chk
(
    input  wire logic        mclk_i,    // system clock
    input  wire logic        rst_n_i,   // sync reset, active low
    input  wire logic        psel_i,    // apb select
    input  wire logic        penable_i, // apb enable
    input  wire logic        pwrite_i,  // apb write
    input  wire logic [9:0]  paddr_i,   // apb address
    input  wire logic [31:0] pwdata_i,  // apb write data
    input  wire logic [31:0] prdata_o,  // apb read data
    input  wire logic        pready_o,  // apb ready
    input  wire logic        pslverr_o, // apb error
    input  wire logic        rx_i,      // serial in
    input  wire logic        ext_clk_i, // external clock level
    input  wire logic        tx_o,      // serial out
    input  wire logic        irq_o      // done request
);
    import asp_pkg::*;
    // ****************************************************************
    // assertions
    // ****************************************************************
    logic mapped;
    assign mapped = (paddr_i == {ASP_CTRL_OFFSET, 2'b00})
                    || (paddr_i == {ASP_DATA_OFFSET, 2'b00})
                    || (paddr_i == {ASP_TIMER_OFFSET, 2'b00});
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_setup(logic [7:0] a);
        psel_i && !penable_i && !pwrite_i && paddr_i == {a, 2'b00};
    endsequence
    sequence s_wr_acc(logic [7:0] a);
        psel_i && penable_i && pwrite_i && paddr_i == {a, 2'b00};
    endsequence
    a_ready_high: assert property (pready_o)
        else $error("ready low");
    a_err_decode: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
        else $error("error response wrong");
    a_reset_idle: assert property ($rose(rst_n_i) |-> tx_o && !irq_o && prdata_o == 32'h0)
        else $error("outputs not idle after reset");
    a_ctrl_bit6: assert property (s_rd_setup(ASP_CTRL_OFFSET) |=>
        prdata_o[ASP_UNUSED_BIT] && prdata_o[31:8] == 24'h0)
        else $error("control bit 6 not one");
    a_data_upper: assert property (s_rd_setup(ASP_DATA_OFFSET) |=> prdata_o[31:8] == 24'h0)
        else $error("data upper bits set");
    a_unmapped_zero: assert property (psel_i && !penable_i && !pwrite_i && !mapped
        |=> prdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_prdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i)
        |=> $stable(prdata_o))
        else $error("read data moved");
    a_irq_set: assert property (s_wr_acc(ASP_CTRL_OFFSET)
        ##0 (pwdata_i[ASP_TI_BIT] || pwdata_i[ASP_RI_BIT]) |=> irq_o)
        else $error("flag write gave no request");
    a_tx_start: assert property (s_wr_acc(ASP_DATA_OFFSET) ##0 tx_o |=> tx_o)
        else $error("start bit began before a bit boundary");
endmodule

bind asp_uart asp_uart_chk chk
(
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i), .ext_clk_i(ext_clk_i),
    .tx_o(tx_o), .irq_o(irq_o)
);

// ### verif/asp_peer.sv
// asp_peer: remote serial node on the port's pins
// assumes bit length set in mclk cycles by the bench
`timescale 1ns/1ps
module asp_peer
(
    input  wire logic mclk_i,   // system clock
    input  wire logic serial_i, // line from the port
    output logic      serial_o  // line to the port
);
    // ****************************************************************
    // sender and listener
    // ****************************************************************
    int         bit_cyc = 8;
    int         nb      = 8;
    int         n_rx    = 0;
    logic [9:0] got;
    initial serial_o = 1'b1;
    // start, data lsb first, ninth when nine is set, stop, idle
    task automatic send(input logic [7:0] d, input logic nine, input logic b9,
                        input logic stp);
        logic [11:0] f;
        f = nine ? {1'b1, stp, b9, d, 1'b0} : {2'b11, stp, d, 1'b0};
        @(posedge mclk_i);
        for (int i = 0; i < 12; i++)
        begin
            serial_o <= f[i];
            repeat (bit_cyc) @(posedge mclk_i);
        end
    endtask
    // sync on the start edge, sample each later bit in its middle
    always
    begin
        @(negedge serial_i);
        repeat (bit_cyc / 2) @(posedge mclk_i);
        for (int i = 0; i <= nb; i++)
        begin
            repeat (bit_cyc) @(posedge mclk_i);
            got[i] = serial_i;
        end
        n_rx++;
    end
endmodule

// ### verif/tb.sv
// tb: self-checking bench for the serial port
// assumes asp_peer on the pins and the checker bound
`timescale 1ns/1ps
module tb;
    import asp_pkg::*;
    logic        mclk_i  = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [9:0]  paddr   = 10'h000;
    logic [31:0] pwdata  = 32'h0;
    logic        ext_clk = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_line;
    logic        tx_line;
    logic        irq;
    logic        err;
    logic [31:0] r;
    int          bad_count = 0;
    int          n_checks  = 0;
    // ****************************************************************
    // clock, design and peer
    // ****************************************************************
    initial forever #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) ext_clk <= ~ext_clk;
    asp_uart dut
    (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx_line), .ext_clk_i(ext_clk),
        .tx_o(tx_line), .irq_o(irq)
    );
    asp_peer peer
    (
        .mclk_i(mclk_i), .serial_i(tx_line), .serial_o(rx_line)
    );
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {a, 2'b00};
        pwdata  <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1)
            @(posedge mclk_i);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs();
        apb(1'b0, ASP_CTRL_OFFSET, 32'h0);
        chk("ctrl reset", 32'h40, r);
        apb(1'b0, ASP_TIMER_OFFSET, 32'h0);
        chk("timer reset", {24'h0, ASP_TIMER_RESET}, r);
        apb(1'b1, ASP_CTRL_OFFSET, 32'h02);
        @(negedge mclk_i);
        chk("irq on flag", 32'h1, {31'h0, irq});
        apb(1'b0, ASP_CTRL_OFFSET, 32'h0);
        chk("ctrl flag", 32'h42, r);
        apb(1'b1, ASP_CTRL_OFFSET, 32'h0);
        @(negedge mclk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, 8'hA4, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, r);
    endtask
    task automatic t_rx(input logic [7:0] c, input logic nine, input logic [7:0] d,
                        input logic b9, input logic stp, input logic [7:0] ec,
                        input logic [7:0] ed);
        apb(1'b1, ASP_CTRL_OFFSET, {24'h0, c});
        peer.send(d, nine, b9, stp);
        apb(1'b0, ASP_CTRL_OFFSET, 32'h0);
        chk("rx ctrl", {24'h0, ec}, r);
        apb(1'b0, ASP_DATA_OFFSET, 32'h0);
        chk("rx data", {24'h0, ed}, r);
    endtask
    task automatic t_tx(input asp_src_type s, input logic [7:0] rel, input int dv,
                        input logic m9, input logic tb8, input logic [7:0] d);
        int k;
        int n0;
        k = 0;
        apb(1'b1, ASP_TIMER_OFFSET, {16'h0, rel, 4'h0, s, 1'b1});
        peer.bit_cyc = ASP_OVF_PER_BIT * (ASP_TIMER_SPAN - rel) * dv;
        peer.nb = m9 ? 9 : 8;
        n0 = peer.n_rx;
        apb(1'b1, ASP_CTRL_OFFSET, {24'h0, m9, 3'h0, tb8, 3'h0});
        apb(1'b1, ASP_DATA_OFFSET, {24'h0, d});
        while (peer.n_rx == n0 && k < 14 * peer.bit_cyc)
        begin
            @(posedge mclk_i);
            k++;
        end
        chk("tx frame seen", 32'h1, {31'h0, peer.n_rx != n0});
        chk("tx done at stop", 32'h1, {31'h0, irq});
        chk("tx byte", {24'h0, d}, {24'h0, peer.got[7:0]});
        chk("tx ninth", {31'h0, m9 ? tb8 : 1'b1}, {31'h0, peer.got[8]});
        chk("tx stop", 32'h1, {31'h0, peer.got[peer.nb]});
        apb(1'b1, ASP_CTRL_OFFSET, 32'h0);
        repeat (2 * peer.bit_cyc) @(posedge mclk_i);
    endtask
    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_regs();
        apb(1'b1, ASP_TIMER_OFFSET, {16'h0, 8'hFC, 4'h0, ASP_SRC_SYS, 1'b1});
        t_rx(8'h10, 1'b0, 8'h5A, 1'b0, 1'b1, 8'h55, 8'h5A);
        t_rx(8'h15, 1'b0, 8'h11, 1'b0, 1'b1, 8'h55, 8'h5A);
        t_rx(8'h30, 1'b0, 8'h22, 1'b0, 1'b0, 8'h70, 8'h5A);
        t_rx(8'h10, 1'b0, 8'h33, 1'b0, 1'b0, 8'h51, 8'h33);
        t_rx(8'hB0, 1'b1, 8'h44, 1'b0, 1'b1, 8'hF0, 8'h33);
        t_rx(8'hB0, 1'b1, 8'h66, 1'b1, 1'b0, 8'hF5, 8'h66);
        t_rx(8'h00, 1'b0, 8'h77, 1'b0, 1'b1, 8'h40, 8'h66);
        t_rx(8'h90, 1'b1, 8'h88, 1'b0, 1'b1, 8'hD1, 8'h88);
        t_tx(ASP_SRC_SYS, 8'hFC, 1, 1'b0, 1'b0, 8'hA5);
        t_tx(ASP_SRC_DIV4, 8'hFE, ASP_DIV4, 1'b1, 1'b1, 8'h3D);
        t_tx(ASP_SRC_DIV12, 8'hFF, ASP_DIV12, 1'b0, 1'b0, 8'hC3);
        t_tx(ASP_SRC_DIV48, 8'hFF, ASP_DIV48, 1'b0, 1'b0, 8'h81);
        t_tx(ASP_SRC_EXT8, 8'hFF, 2 * ASP_EXT_DIV, 1'b1, 1'b0, 8'h5B);
        finish_test();
    end
    initial
    begin
        #(25 * 20000);
        bad_count++;
        finish_test();
    end
endmodule
